// *** design/ppac_ctrl.sv ***
// pwm prescaler, align-mode and pair-join configuration with axi4-lite slave
// assumes WAIT_I and FREEZE_I come from other clock logic and are synchronised here
module ppac_ctrl
  import ppac_pkg::*;
(
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // axi4-lite write address, data and response
  input wire logic [9:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  // axi4-lite read
  input wire logic [9:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  // operating modes from the system
  input wire logic WAIT_I,
  input wire logic FREEZE_I,
  // prescaled ticks and channel configuration
  output logic CLOCK_A_TICK_O,
  output logic CLOCK_B_TICK_O,
  output ppac_pkg::ppac_chan_cfg_t CHAN_CFG_O
);
  import ppac_pkg::*;

  // register state
  logic [7:0] prescale_q, prescale_d;
  logic [7:0] align_q, align_d;
  logic [7:0] control_q, control_d;
  logic [7:0] enable_q, enable_d;
  logic [6:0] presc_cnt_q, presc_cnt_d;
  logic tick_a_q, tick_a_d, tick_b_q, tick_b_d;
  ppac_chan_cfg_t cfg_q, cfg_d;
  logic wait_s1_q, wait_s2_q, frz_s1_q, frz_s2_q;
  // bus state
  logic aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [9:0] awaddr_q, awaddr_d;
  logic [7:0] wdata_q, wdata_d;
  logic wstrb0_q, wstrb0_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [1:0] rresp_q, rresp_d;
  logic [7:0] rdata_q, rdata_d;
  logic presc_run;
  // word address of the read request; the byte lanes below bit 2 are ignored
  logic [9:0] ar_word;
  // readies kept in flops so every bus output comes straight from a register
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic arready_q, arready_d;

  // maps an address to a known register
  function automatic logic addr_hit(input logic [9:0] a);
    addr_hit = (a == PRESCALE_ADDR) || (a == ALIGN_ADDR) ||
               (a == CONTROL_ADDR) || (a == ENABLE_ADDR);
  endfunction : addr_hit

  // tick when all counter bits below the selected ratio are ones
  function automatic logic div_tick(input logic [2:0] sel, input logic [6:0] cnt);
    logic [6:0] low_mask;
    low_mask = 7'((8'h01 << sel) - 8'h01);
    div_tick = ((cnt & low_mask) == low_mask);
  endfunction : div_tick

  // mode inputs cross in through two flops each
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      wait_s1_q <= 1'b0;
      wait_s2_q <= 1'b0;
      frz_s1_q <= 1'b0;
      frz_s2_q <= 1'b0;
    end
    else
    begin
      wait_s1_q <= WAIT_I;
      wait_s2_q <= wait_s1_q;
      frz_s1_q <= FREEZE_I;
      frz_s2_q <= frz_s1_q;
    end
  end

  // prescaler gating: wait stop, freeze stop, all channels off
  // the stop holds the count itself, so no gated clock ever reaches the flops
  always_comb
  begin
    presc_run = 1'b1;
    if (control_q[WAIT_STOP_BIT] && wait_s2_q)
      presc_run = 1'b0;
    if (control_q[FREEZE_STOP_BIT] && frz_s2_q)
      presc_run = 1'b0;
    if (enable_q == 8'h00)
      presc_run = 1'b0;
  end

  // free-running counter holds its value while stopped, so counts resume
  // the 7-bit wrap gives the divide-by-128 period with no extra compare
  always_comb
  begin
    presc_cnt_d = presc_cnt_q;
    tick_a_d = 1'b0;
    tick_b_d = 1'b0;
    if (presc_run)
    begin
      presc_cnt_d = presc_cnt_q + 7'h01;
      tick_a_d = div_tick(prescale_q[CLKA_LSB +: 3], presc_cnt_q);
      tick_b_d = div_tick(prescale_q[CLKB_LSB +: 3], presc_cnt_q);
    end
  end

  // channel configuration: odd channel governs a joined pair
  always_comb
  begin
    cfg_d.center_mode = align_q;
    cfg_d.joined = control_q[JOIN_LSB +: 4];
    cfg_d.enable_eff = enable_q;
    cfg_d.out_allowed = 8'hFF;
    for (int p = 0; p < 4; p++)
    begin
      if (control_q[JOIN_LSB + p])
      begin
        cfg_d.enable_eff[2 * p] = enable_q[2 * p + 1];
        cfg_d.out_allowed[2 * p] = 1'b0;
        cfg_d.center_mode[2 * p] = align_q[2 * p + 1];
      end
    end
  end

  // axi write path, address and data accepted in either order
  always_comb
  begin
    aw_got_d = aw_got_q;
    w_got_d = w_got_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb0_d = wstrb0_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    prescale_d = prescale_q;
    align_d = align_q;
    control_d = control_q;
    enable_d = enable_q;
    if (AWVALID_I && !aw_got_q && !bvalid_q)
    begin
      aw_got_d = 1'b1;
      awaddr_d = {AWADDR_I[9:2], 2'b00};
    end
    if (WVALID_I && !w_got_q && !bvalid_q)
    begin
      w_got_d = 1'b1;
      wdata_d = WDATA_I[7:0];
      wstrb0_d = WSTRB_I[0];
    end
    if (aw_got_q && w_got_q)
    begin
      aw_got_d = 1'b0;
      w_got_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = addr_hit(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      if (wstrb0_q)
      begin
        case (awaddr_q)
          PRESCALE_ADDR: prescale_d = wdata_q & PRESCALE_MASK;
          ALIGN_ADDR: align_d = wdata_q;
          CONTROL_ADDR: control_d = wdata_q & CONTROL_MASK;
          ENABLE_ADDR: enable_d = wdata_q;
          default: ;
        endcase
      end
    end
    if (bvalid_q && BREADY_I)
      bvalid_d = 1'b0;
    // a slot reopens only once its response has been taken
    awready_d = !aw_got_d && !bvalid_d;
    wready_d = !w_got_d && !bvalid_d;
  end

  // low address bits are ignored, as on the write side
  assign ar_word = {ARADDR_I[9:2], 2'b00};

  // axi read path, one cycle to answer, held until rready
  always_comb
  begin
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (rvalid_q && RREADY_I)
      rvalid_d = 1'b0;
    if (ARVALID_I && !rvalid_q)
    begin
      rvalid_d = 1'b1;
      rresp_d = addr_hit(ar_word) ? RESP_OKAY : RESP_SLVERR;
      case (ar_word)
        PRESCALE_ADDR: rdata_d = prescale_q;
        ALIGN_ADDR: rdata_d = align_q;
        CONTROL_ADDR: rdata_d = control_q;
        ENABLE_ADDR: rdata_d = enable_q;
        default: rdata_d = 8'h00;
      endcase
    end
    arready_d = !rvalid_d;
  end

  // all state except the mode-input synchronisers registered here
  always_ff @(posedge CLOCK_I)
  begin
    if (RST_I)
    begin
      prescale_q <= PRESCALE_RST;
      align_q <= ALIGN_RST;
      control_q <= CONTROL_RST;
      enable_q <= ENABLE_RST;
      presc_cnt_q <= PRESCALER_RST;
      tick_a_q <= 1'b0;
      tick_b_q <= 1'b0;
      cfg_q <= '0;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 10'h000;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 8'h00;
      // readies come up high so the first request after reset is taken at once
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      arready_q <= 1'b1;
    end
    else
    begin
      prescale_q <= prescale_d;
      align_q <= align_d;
      control_q <= control_d;
      enable_q <= enable_d;
      presc_cnt_q <= presc_cnt_d;
      tick_a_q <= tick_a_d;
      tick_b_q <= tick_b_d;
      cfg_q <= cfg_d;
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb0_q <= wstrb0_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
    end
  end

  // outputs straight from flops
  assign AWREADY_O = awready_q;
  assign WREADY_O = wready_q;
  assign BVALID_O = bvalid_q;
  assign BRESP_O = bresp_q;
  assign ARREADY_O = arready_q;
  assign RVALID_O = rvalid_q;
  assign RRESP_O = rresp_q;
  assign RDATA_O = {24'h00_0000, rdata_q};
  assign CLOCK_A_TICK_O = tick_a_q;
  assign CLOCK_B_TICK_O = tick_b_q;
  assign CHAN_CFG_O = cfg_q;

endmodule : ppac_ctrl

// *** design/ppac_pkg.sv ***
// package for the pwm prescale, align and pair-join control block
// assumes one bus clock; registers reached over axi4-lite with 32-bit data
package ppac_pkg;

  // register byte addresses (printed offsets are indices, byte address is four times)
  localparam logic [7:0] PRESCALE_IDX = 8'h03;
  localparam logic [7:0] ALIGN_IDX = 8'h04;
  localparam logic [7:0] CONTROL_IDX = 8'h05;
  localparam logic [7:0] ENABLE_IDX = 8'h00;
  localparam logic [9:0] PRESCALE_ADDR = {PRESCALE_IDX, 2'b00};
  localparam logic [9:0] ALIGN_ADDR = {ALIGN_IDX, 2'b00};
  localparam logic [9:0] CONTROL_ADDR = {CONTROL_IDX, 2'b00};
  localparam logic [9:0] ENABLE_ADDR = {ENABLE_IDX, 2'b00};

  // field positions
  localparam int CLKB_LSB = 4;
  localparam int CLKA_LSB = 0;
  localparam int WAIT_STOP_BIT = 3;
  localparam int FREEZE_STOP_BIT = 2;
  localparam int JOIN_LSB = 4;

  // writable masks; undocumented bits read zero
  localparam logic [7:0] PRESCALE_MASK = 8'h77;
  localparam logic [7:0] CONTROL_MASK = 8'hFC;

  // reset values
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic [7:0] ALIGN_RST = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [6:0] PRESCALER_RST = 7'h00;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // per-channel configuration handed to the counters
  typedef struct packed {
    logic [7:0] center_mode;   // 1 center-aligned
    logic [7:0] enable_eff;    // effective channel enables
    logic [7:0] out_allowed;   // output line may drive
    logic [3:0] joined;        // pair joins 01,23,45,67
  } ppac_chan_cfg_t;

  // bus write / read slot state
  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_RESP = 3'b010,
    WR_HOLD = 3'b100
  } ppac_wr_state_t;

endpackage : ppac_pkg

// *** test/ppac_ctrl_assertions.sv ***
// checker: bus answer timing, read-zero bits, pair-join config, idle prescaler
// assumes it is bound onto ppac_ctrl; one clock, synchronous high reset
module ppac_ctrl_chk
  import ppac_pkg::*;
(
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // register bus
  input wire logic [9:0] AWADDR_I,
  input wire logic AWVALID_I,
  input wire logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  input wire logic WREADY_O,
  input wire logic [1:0] BRESP_O,
  input wire logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [9:0] ARADDR_I,
  input wire logic ARVALID_I,
  input wire logic ARREADY_O,
  input wire logic [31:0] RDATA_O,
  input wire logic [1:0] RRESP_O,
  input wire logic RVALID_O,
  input wire logic RREADY_I,
  // modes and results
  input wire logic WAIT_I,
  input wire logic FREEZE_I,
  input wire logic CLOCK_A_TICK_O,
  input wire logic CLOCK_B_TICK_O,
  input wire ppac_pkg::ppac_chan_cfg_t CHAN_CFG_O
);
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I);
  logic [7:0] jm;
  logic [7:0] en;
  logic [7:0] cm;
  // even member of each joined pair, where the odd settings must rule
  assign jm = {1'b0, CHAN_CFG_O.joined[3], 1'b0, CHAN_CFG_O.joined[2],
    1'b0, CHAN_CFG_O.joined[1], 1'b0, CHAN_CFG_O.joined[0]};
  assign en = CHAN_CFG_O.enable_eff;
  assign cm = CHAN_CFG_O.center_mode;
  // write halves offered together, read request taken
  sequence wr_taken;
    AWVALID_I && AWREADY_O && WVALID_I && WREADY_O;
  endsequence
  sequence rd_taken;
    ARVALID_I && ARREADY_O;
  endsequence
  a_wr_answer: assert property (wr_taken |-> ##[1:2] BVALID_O)
    else $error("write answer missing");
  a_rd_answer: assert property (rd_taken |=> RVALID_O)
    else $error("read answer missing");
  a_busy_refuse: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
    else $error("write taken while answering");
  a_bresp_hold: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
    else $error("write answer dropped");
  a_rdata_hold: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
    else $error("read answer dropped");
  a_rdata_upper: assert property (RVALID_O |-> RDATA_O[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_join_out: assert property ((CHAN_CFG_O.out_allowed & jm) == 8'h00)
    else $error("even line of joined pair on");
  a_join_enable: assert property (((en ^ (en >> 1)) & jm) == 8'h00)
    else $error("joined pair enable not odd");
  a_join_mode: assert property (((cm ^ (cm >> 1)) & jm) == 8'h00)
    else $error("joined pair mode not odd");
  a_idle_ticks: assert property ((en == 8'h00 && CHAN_CFG_O.joined == 4'h0) [*3]
    |-> !CLOCK_A_TICK_O && !CLOCK_B_TICK_O)
    else $error("ticks with all channels off");
endmodule : ppac_ctrl_chk

bind ppac_ctrl ppac_ctrl_chk i_chk (.*);

// *** test/ppac_ctrl_tb.sv ***
// self-checking bench for ppac_ctrl over axi4-lite
// assumes the checker binds itself; ticks are counted at falling edges
module ppac_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ppac_pkg::*;
  logic CLOCK_I, RST_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I, WAIT_I, FREEZE_I;
  logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, CLOCK_A_TICK_O, CLOCK_B_TICK_O;
  logic [9:0] AWADDR_I, ARADDR_I;
  logic [31:0] WDATA_I, RDATA_O;
  logic [3:0] WSTRB_I;
  logic [1:0] BRESP_O, RRESP_O;
  ppac_chan_cfg_t CHAN_CFG_O;
  int miscompares = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h0000_8556;
  localparam logic [9:0] ADDRS [4] = '{ENABLE_ADDR, PRESCALE_ADDR, ALIGN_ADDR, CONTROL_ADDR};
  localparam logic [7:0] MSK [4] = '{8'hFF, PRESCALE_MASK, 8'hFF, CONTROL_MASK};
  ppac_ctrl i_dut (.*);
  // 100 mhz clock
  initial
  begin
    CLOCK_I = 1'b0;
    forever #5 CLOCK_I = ~CLOCK_I;
  end
  // xorshift, seed 34134 so every run repeats
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic hang();
    miscompares++;
    conclude();
  endtask : hang
  // one bus transfer; valids drop right after the edge that takes them
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d,
      output logic [31:0] q, output logic [1:0] r);
    logic [2:0] p;
    int n;
    p = {w, w, !w};
    AWADDR_I <= a;
    ARADDR_I <= a;
    WDATA_I <= {24'h00_0000, d};
    for (n = 0; n < 64; n++)
    begin
      {AWVALID_I, WVALID_I, ARVALID_I} <= p;
      @(posedge CLOCK_I);
      if (p == 3'b000 && (BVALID_O || RVALID_O))
        break;
      p = p & ~{AWREADY_O, WREADY_O, ARREADY_O};
    end
    q = RDATA_O;
    r = w ? BRESP_O : RRESP_O;
    if (n == 64)
      hang();
  endtask : xfer
  // write then read back
  task automatic wrc(input logic [9:0] a, input logic [7:0] d, input logic [7:0] e);
    logic [31:0] q;
    logic [1:0] r;
    xfer(1'b1, a, d, q, r);
    check(r, RESP_OKAY);
    xfer(1'b0, a, 8'h00, q, r);
    check(q, e);
  endtask : wrc
  // skip the settling after a change, then count ticks
  task automatic ticks(input int len, output logic [31:0] ca, output logic [31:0] cb);
    ca = 32'h0000_0000;
    cb = 32'h0000_0000;
    repeat (8) @(negedge CLOCK_I);
    repeat (len)
    begin
      @(negedge CLOCK_I);
      ca = ca + CLOCK_A_TICK_O;
      cb = cb + CLOCK_B_TICK_O;
    end
  endtask : ticks
  // joined pair: even follows odd enable and mode, even line off
  function automatic ppac_chan_cfg_t cfg_of(logic [7:0] en, logic [7:0] al, logic [3:0] j);
    ppac_chan_cfg_t c;
    c = '{center_mode: al, enable_eff: en, out_allowed: 8'hFF, joined: j};
    for (int p = 0; p < 4; p++)
      if (j[p])
      begin
        c.enable_eff[2*p] = en[2*p+1];
        c.center_mode[2*p] = al[2*p+1];
        c.out_allowed[2*p] = 1'b0;
      end
    return c;
  endfunction : cfg_of
  // hang guard
  initial
  begin
    repeat (100000) @(posedge CLOCK_I);
    hang();
  end
  initial
  begin
    logic [31:0] q, ca, cb;
    logic [1:0] r;
    RST_I = 1'b1;
    {AWVALID_I, WVALID_I, ARVALID_I, WAIT_I, FREEZE_I} = 5'h00;
    {BREADY_I, RREADY_I} = 2'b11;
    {AWADDR_I, ARADDR_I, WDATA_I} = '0;
    WSTRB_I = 4'h1;
    repeat (12) @(posedge CLOCK_I);
    RST_I <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b0, ADDRS[i], 8'h00, q, r);
      check(q, 32'h0000_0000);
    end
    // random data, all ones on the control register; reserved bits must read zero
    repeat (10)
      for (int i = 0; i < 4; i++)
      begin
        if (i == 2)
          wrc(ENABLE_ADDR, 8'h00, 8'h00);
        q = (i == 3) ? 32'h0000_00FF : rnd();
        wrc(ADDRS[i], q[7:0], q[7:0] & MSK[i]);
      end
    xfer(1'b1, 10'h3FC, 8'hA5, q, r);
    check(r, RESP_SLVERR);
    xfer(1'b0, 10'h3FC, 8'h00, q, r);
    check(q, 32'h0000_0000);
    // a write with its byte strobe off answers okay and stores nothing
    wrc(ALIGN_ADDR, 8'h3C, 8'h3C);
    WSTRB_I <= 4'h0;
    xfer(1'b1, ALIGN_ADDR, 8'hC3, q, r);
    check(r, RESP_OKAY);
    WSTRB_I <= 4'h1;
    xfer(1'b0, ALIGN_ADDR, 8'h00, q, r);
    check(q, 32'h0000_003C);
    // random join, align and enable mixes
    repeat (16)
    begin
      ca = rnd();
      wrc(ENABLE_ADDR, 8'h00, 8'h00);
      wrc(ALIGN_ADDR, ca[15:8], ca[15:8]);
      wrc(CONTROL_ADDR, ca[23:16], ca[23:16] & CONTROL_MASK);
      wrc(ENABLE_ADDR, ca[7:0], ca[7:0]);
      check(CHAN_CFG_O, cfg_of(ca[7:0], ca[15:8], ca[23:20]));
    end
    // every divide ratio on both clocks, changed while running
    wrc(ENABLE_ADDR, 8'h00, 8'h00);
    wrc(CONTROL_ADDR, 8'h00, 8'h00);
    wrc(ENABLE_ADDR, 8'h80, 8'h80);
    for (int s = 0; s < 8; s++)
    begin
      wrc(PRESCALE_ADDR, 8'((7 - s) * 16 + s), 8'((7 - s) * 16 + s));
      ticks(256, ca, cb);
      check(ca, 32'h0000_0100 >> s);
      check(cb, 32'h0000_0100 >> (7 - s));
    end
    wrc(PRESCALE_ADDR, 8'h00, 8'h00);
    // wait or freeze input high, each stop bit on and off
    for (int k = 0; k < 8; k++)
    begin
      wrc(CONTROL_ADDR, {4'h0, k[1:0], 2'b00}, {4'h0, k[1:0], 2'b00});
      WAIT_I <= !k[2];
      FREEZE_I <= k[2];
      ticks(32, ca, cb);
      check(ca, ((k[1] && !k[2]) || (k[0] && k[2])) ? 0 : 32);
    end
    FREEZE_I <= 1'b0;
    ticks(32, ca, cb);
    check(ca, 32'h0000_0020);
    wrc(ENABLE_ADDR, 8'h00, 8'h00);
    ticks(32, ca, cb);
    check({ca[15:0], cb[15:0]}, 32'h0000_0000);
    // second reset in mid-run: every register and the config return to rest
    wrc(PRESCALE_ADDR, 8'h35, 8'h35);
    RST_I <= 1'b1;
    repeat (2) @(posedge CLOCK_I);
    RST_I <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b0, ADDRS[i], 8'h00, q, r);
      check(q, 32'h0000_0000);
    end
    check(CHAN_CFG_O, cfg_of(ENABLE_RST, ALIGN_RST, CONTROL_RST[JOIN_LSB +: 4]));
    conclude();
  end
endmodule : ppac_ctrl_tb
